/* sim/dram_module_model.sv */
// Behavioural model of the 2M x 32 hyper page DRAM module
`timescale 1ns/1ps
`default_nettype none
module dram_module_model (
  input wire logic slow,
  input wire logic odd_code,
  input wire logic [3:0] row_strobe_n,
  input wire logic [3:0] column_strobe_n,
  input wire logic [9:0] mux_address,
  input wire logic write_enable_n,
  input wire logic [31:0] data_bus_out,
  input wire logic data_bus_oe,
  output logic [31:0] data_bus_in,
  output logic speed_id_pin0,
  output logic speed_id_pin1,
  output logic speed_id_pin2,
  output logic speed_id_pin3,
  output int refresh_count
);
  logic [31:0] mem [int]; // Sparse word store
  logic [20:0] key; // Bank, row, column of the open word
  logic [31:0] q = 32'h0; // Last read word
  logic drv = 1'b0; // Module drives the data lines
  realtime rfall = 0;
  realtime t;
  wire logic row_hi = &row_strobe_n;
  initial refresh_count = 0;
  // Open pins pull high; third pin grounded on slow grade
  // First pin grounded only to present an unknown code
  assign speed_id_pin0 = ~odd_code;
  assign speed_id_pin1 = 1'b1;
  assign speed_id_pin2 = ~slow;
  assign speed_id_pin3 = 1'b1;
  // Released lines show the inverse so stale data never passes
  assign data_bus_in = data_bus_oe ? data_bus_out : (drv ? q : ~q);
  // Column low before row fall is a refresh
  always @(negedge row_hi) begin
    if (column_strobe_n === 4'h0) begin
      refresh_count++;
    end else begin
      rfall = $realtime;
      key[20:10] = {row_strobe_n[0], mux_address};
    end
  end
  // Early write keeps lines released; reads hold old data till new,
  always @(negedge column_strobe_n[0]) begin
    if (!row_hi) begin
      key[9:0] = mux_address;
      if (!write_enable_n) begin
        mem[key] = data_bus_out;
        drv = 1'b0;
      end else begin
        // Latest of row and column paths, 1 ns early
        t = rfall + (slow ? 70 : 60) - $realtime;
        if (t < (slow ? 35 : 30)) t = slow ? 35 : 30;
        q <= #(t - 1) (mem.exists(key) ? mem[key] : 32'h0);
        drv <= #(t - 1) 1'b1;
      end
    end
  end
  // Lines released once row and column strobes are both high
  always @(posedge row_hi or posedge column_strobe_n[0]) begin
    if (row_hi && column_strobe_n[0]) drv <= 1'b0;
  end
endmodule
`default_nettype wire

/* sim/test_dram_page_host.sv */
// Self-checking bench for the DRAM page host controller
`timescale 1ns/1ps
`default_nettype none
module test_dram_page_host;
  import dram_host_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic slow = 1'b0;
  logic odd = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  wire logic req_ready, resp_valid, grade_ready, grade_slow, grade_unknown;
  wire logic [DATA_W-1:0] resp_rdata, data_bus_out, data_bus_in;
  wire logic [3:0] row_strobe_n, column_strobe_n;
  wire logic [9:0] mux_address;
  wire logic write_enable_n, data_bus_oe, pd0, pd1, pd2, pd3;
  wire logic row_hi = &row_strobe_n;
  int refresh_count, last_ref, since_ref;
  int fail_count = 0;
  int n_compared = 0;
  logic [15:0] seed = 16'hAF90;
  logic [DATA_W-1:0] ref_mem [int]; // Expected words by address
  logic [ADDR_W-1:0] addrs [$];
  logic cur_write = 1'b0;
  realtime t_rfall = 0, t_rrise = 0, t_crise = 0;
  always #(CLK_NS / 2) clk = ~clk;
  dram_page_host DUT (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .grade_ready(grade_ready), .grade_slow(grade_slow),
    .grade_unknown(grade_unknown), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .mux_address(mux_address),
    .write_enable_n(write_enable_n), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in),
    .speed_id_pin0(pd0), .speed_id_pin1(pd1), .speed_id_pin2(pd2),
    .speed_id_pin3(pd3));
  dram_module_model module0 (.slow(slow), .odd_code(odd),
    .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .mux_address(mux_address),
    .write_enable_n(write_enable_n), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in),
    .speed_id_pin0(pd0), .speed_id_pin1(pd1), .speed_id_pin2(pd2),
    .speed_id_pin3(pd3), .refresh_count(refresh_count));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic rnd(output logic [31:0] r);
    seed = lfsr(seed);
    r[15:0] = seed;
    seed = lfsr(seed);
    r[31:16] = seed;
  endtask
  // One word access; request held until taken, answer awaited bounded
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    logic rdy;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    cur_write <= wr;
    n = 0;
    do begin
      @(negedge clk);
      rdy = req_ready;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 2000);
    if (rdy !== 1'b1) hang();
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 20);
    if (resp_valid !== 1'b1) hang();
    if (wr) ref_mem[a] = d;
    else chk(resp_rdata, ref_mem[a]);
  endtask
  // Strobe widths and ordering seen at the module pins
  always @(negedge row_hi) begin
    if (rst_b) chk($realtime - t_rrise >= (slow ? 50 : 40), 1);
    if (rst_b && column_strobe_n[0])
      chk($realtime - t_crise >= 5, 1);
    t_rfall = $realtime;
  end
  always @(posedge row_hi) begin
    if (rst_b) chk($realtime - t_rfall >= (slow ? 70 : 60), 1);
    t_rrise = $realtime;
  end
  always @(negedge column_strobe_n[0]) begin
    if (!row_hi && rst_b) begin
      chk(write_enable_n, !cur_write);
      chk($realtime - t_rfall >= 14, 1);
    end
  end
  always @(posedge column_strobe_n[0]) begin
    if (!row_hi && !cur_write) chk(write_enable_n, 1'b1);
    t_crise = $realtime;
  end
  // Refresh gap must stay within 16 ms over 1024 rows
  always @(posedge clk) begin
    last_ref <= refresh_count;
    if (!grade_ready || refresh_count != last_ref) since_ref <= 0;
    else since_ref <= since_ref + 1;
    if (since_ref == 782) chk(since_ref, 781);
  end
  initial begin
    logic [31:0] r;
    logic [ADDR_W-1:0] a;
    int n;
    for (int g = 0; g < 3; g++) begin
      rst_b <= 1'b0;
      slow <= g[0] | g[1];
      odd <= g[1];
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (grade_ready !== 1'b1 && n < 50);
      if (grade_ready !== 1'b1) hang();
      chk(grade_slow, g[0] | g[1]);
      chk(grade_unknown, g[1]);
      addrs.delete();
      // Page neighbour and other bank follow the first random word
      for (int i = 0; i < 8; i++) begin
        rnd(r);
        a = (i == 1) ? addrs[0] ^ 21'h00001 :
            (i == 2) ? addrs[0] ^ 21'h100000 : r[ADDR_W-1:0];
        addrs.push_back(a);
        rnd(r);
        access(1'b1, a, r);
      end
      foreach (addrs[i]) access(1'b0, addrs[i], 32'h0);
      $display("test access grade %0d done", g);
      n = refresh_count;
      repeat (900) @(posedge clk);
      chk(refresh_count > n, 1);
      foreach (addrs[i]) access(1'b0, addrs[i], 32'h0);
      $display("test refresh grade %0d done", g);
    end
    close_out();
  end
endmodule
`default_nettype wire

/* verilog/dram_host_pkg.sv */
// Shared constants, timing figures and state codes for the DRAM host
`default_nettype none
package dram_host_pkg;
  localparam int CLK_NS = 20;       // 50 MHz system clock
  localparam int CNT_W = 10;        // Width of every cycle counter
  localparam int ROW_W = 10;        // Row address bits
  localparam int COL_W = 10;        // Column address bits
  localparam int ADDR_W = 21;       // 2,097,152 words
  localparam int DATA_W = 32;       // Word width
  localparam int STROBE_W = 4;      // Four row and four column strobes
  localparam int COL_LSB = 0;       // Word address: column field
  localparam int ROW_LSB = 10;      // Word address: row field
  localparam int BANK_BIT = 20;     // Word address: bank select
  // Active-low strobe patterns
  localparam logic [3:0] STROBE_IDLE = 4'hF;
  localparam logic [3:0] STROBE_ALL = 4'h0;
  localparam logic [3:0] BANK0_STROBE = 4'hC;
  localparam logic [3:0] BANK1_STROBE = 4'h3;
  // Times in ns, fast grade then slow grade where the two grades differ
  localparam int T_RC_F_NS = 104;
  localparam int T_RC_S_NS = 124;
  localparam int T_RP_F_NS = 40;
  localparam int T_RP_S_NS = 50;
  localparam int T_RAS_F_NS = 60;
  localparam int T_RAS_S_NS = 70;
  localparam int T_RAS_MAX_NS = 10000;
  localparam int T_RCD_NS = 14;
  localparam int T_RAC_F_NS = 60;
  localparam int T_RAC_S_NS = 70;
  localparam int T_CAC_F_NS = 15;
  localparam int T_CAC_S_NS = 18;
  localparam int T_AA_F_NS = 30;
  localparam int T_AA_S_NS = 35;
  localparam int T_LEAD_F_NS = 30;  // Column address lead to row rise
  localparam int T_LEAD_S_NS = 35;
  localparam int T_CSH_F_NS = 40;
  localparam int T_CSH_S_NS = 50;
  localparam int T_RHCP_F_NS = 35;
  localparam int T_RHCP_S_NS = 40;
  localparam int T_HPC_F_NS = 25;
  localparam int T_HPC_S_NS = 30;
  localparam int T_REF_NS = 16000000; // 16 ms window
  localparam int REF_ROWS = 1024;
  // Least time rounded up to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  // Longest time rounded down, never below one
  function automatic int cyc_dn(input int ns);
    return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
  endfunction
  function automatic int max3(input int a, input int b, input int c);
    return (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
  endfunction
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(cyc_up(T_RCD_NS));
  localparam logic [CNT_W-1:0] RAS_MAX_CYC = CNT_W'(cyc_dn(T_RAS_MAX_NS));
  localparam logic [CNT_W-1:0] PAGE_GUARD_CYC = CNT_W'(16);
  localparam logic [CNT_W-1:0] PAGE_LIMIT_CYC = RAS_MAX_CYC - PAGE_GUARD_CYC;
  localparam logic [CNT_W-1:0] HPC_CYC = CNT_W'(cyc_up(T_HPC_S_NS));
  localparam logic [CNT_W-1:0] STRAP_SETTLE_CYC = CNT_W'(4);
  localparam logic [CNT_W-1:0] REF_DEADLINE_CYC =
    CNT_W'(cyc_dn(T_REF_NS / REF_ROWS));
  localparam logic [CNT_W-1:0] REF_MARGIN_CYC = CNT_W'(32);
  localparam logic [CNT_W-1:0] REF_SPACING_CYC =
    REF_DEADLINE_CYC - REF_MARGIN_CYC;
  // Controller states, one-hot
  typedef enum logic [7:0] {
    ST_INIT = 8'h01,
    ST_IDLE = 8'h02,
    ST_ROW = 8'h04,
    ST_COL = 8'h08,
    ST_PAGE = 8'h10,
    ST_PRECH = 8'h20,
    ST_REF_COL = 8'h40,
    ST_REF_ROW = 8'h80
  } state_t;
endpackage
`default_nettype wire

/* verilog/dram_page_host.sv */
// Host controller for a 2M x 32 hyper page DRAM module
// Functional notes
// [R1] 21-bit word address: bank, row, column
// [R2] Four row, four column strobes, shared bus
// [R3] Refresh every row within sixteen milliseconds
// [R4] Honour cycle time, row low/high widths
// [R5] Row-to-column strobe and address minimum delays
// [R6] Late column timing only moves data validity
// [R7] Data valid at latest of three paths
// [R8] Grade access limits fix the sample point
// [R9] Column strobe high before row strobe falls
// [R10] Column address leads row strobe rise
// [R11] Read: write enable high by column fall
// [R12] Read: write enable high until strobes rise
// [R13] Page accesses spaced by page cycle time
// [R14] Third speed pin grounded means slow
// [R15] Write enable before column fall: early write
// [R16] Module holds page data after column fall
// [R17] Module accepts three refresh forms
// [R18] Read speed pins before any access
`timescale 1ns/1ps
`default_nettype none
module dram_page_host (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [dram_host_pkg::ADDR_W-1:0] req_addr,
  input wire logic [dram_host_pkg::DATA_W-1:0] req_wdata,
  output logic resp_valid,
  output logic [dram_host_pkg::DATA_W-1:0] resp_rdata,
  output logic grade_ready,
  output logic grade_slow,
  output logic grade_unknown,
  output logic [dram_host_pkg::STROBE_W-1:0] row_strobe_n,
  output logic [dram_host_pkg::STROBE_W-1:0] column_strobe_n,
  output logic [dram_host_pkg::ROW_W-1:0] mux_address,
  output logic write_enable_n,
  output logic [dram_host_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe,
  input wire logic [dram_host_pkg::DATA_W-1:0] data_bus_in,
  input wire logic speed_id_pin0,
  input wire logic speed_id_pin1,
  input wire logic speed_id_pin2,
  input wire logic speed_id_pin3
);
  import dram_host_pkg::*;

  logic rst_meta;          // First reset stage, read only by the second
  logic sys_rst_b;         // Synchronised reset used everywhere else
  state_t state, next_state;
  logic [STROBE_W-1:0] next_row_n, next_col_n;
  logic [ROW_W-1:0] next_addr;
  logic next_we_n, next_oe, next_rvalid;
  logic [DATA_W-1:0] next_dout, next_rdata;
  logic ref_done, next_ref_done; // One-cycle pulse when a refresh starts
  logic refresh_due;
  logic open_bank, next_bank; // Bank of the open row
  logic [ROW_W-1:0] open_row, next_row;
  logic [COL_W-1:0] open_col, next_col;
  logic cur_write, next_write; // Access in flight is a write
  logic [CNT_W-1:0] ras_cnt, next_ras_cnt; // Cycles since row strobe fell
  logic [CNT_W-1:0] col_cnt, next_col_cnt; // Cycles since column fell
  logic [CNT_W-1:0] pre_cnt, next_pre_cnt; // Cycles since row strobe rose
  logic [CNT_W-1:0] tras_cyc, trp_cyc, trc_cyc;
  logic [CNT_W-1:0] rac_cyc, lead_cyc, colacc_cyc;
  logic page_match; // Request falls in the open row
  logic take, close_wanted; // Handshake now; open row must close

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (&v) ? v : v + CNT_ONE;
  endfunction

  // Reset: asserted at once, released through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      sys_rst_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      sys_rst_b <= rst_meta;
    end
  end

  // Grade pins are read once after reset
  speed_grade_select u_grade (
    .clk(clk),
    .sys_rst_b(sys_rst_b),
    .speed_id_pin0(speed_id_pin0),
    .speed_id_pin1(speed_id_pin1),
    .speed_id_pin2(speed_id_pin2),
    .speed_id_pin3(speed_id_pin3),
    .grade_ready(grade_ready),
    .grade_slow(grade_slow),
    .grade_unknown(grade_unknown),
    .tras_cyc(tras_cyc),
    .trp_cyc(trp_cyc),
    .trc_cyc(trc_cyc),
    .rac_cyc(rac_cyc),
    .lead_cyc(lead_cyc),
    .colacc_cyc(colacc_cyc)
  );

  // Refresh request source
  refresh_pacer u_refresh (
    .clk(clk),
    .sys_rst_b(sys_rst_b),
    .refresh_done(ref_done),
    .refresh_due(refresh_due)
  );

  // Page hit needs same bank and row, with room left in the row window
  assign page_match = (state == ST_PAGE) &&
    (req_addr[BANK_BIT] == open_bank) &&
    (req_addr[ROW_LSB +: ROW_W] == open_row) &&
    (ras_cnt < PAGE_LIMIT_CYC);
  // No access before the grade is known (see [R18])
  assign req_ready = grade_ready && !refresh_due &&
    ((state == ST_IDLE) || page_match);
  assign take = req_valid && req_ready;
  assign close_wanted = refresh_due || (req_valid && !page_match) ||
    (ras_cnt >= PAGE_LIMIT_CYC);

  // Next-state and pin values
  always_comb begin
    next_state = state;
    next_row_n = row_strobe_n;
    next_col_n = column_strobe_n;
    next_addr = mux_address;
    next_we_n = write_enable_n;
    next_dout = data_bus_out;
    next_oe = data_bus_oe;
    next_rdata = resp_rdata;
    next_rvalid = 1'b0;
    next_ref_done = 1'b0;
    next_bank = open_bank;
    next_row = open_row;
    next_col = open_col;
    next_write = cur_write;
    next_ras_cnt = sat_inc(ras_cnt);
    next_col_cnt = sat_inc(col_cnt);
    next_pre_cnt = sat_inc(pre_cnt);
    case (state)
      ST_INIT: begin
        if (grade_ready) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (refresh_due && grade_ready) begin
          // Column strobes first: column-before-row refresh (see [R17])
          next_col_n = STROBE_ALL;
          next_state = ST_REF_COL;
        end else if (take) begin
          // Bank picks the strobe pair, row goes out now (see [R1] [R2] [R9])
          next_row_n = req_addr[BANK_BIT] ? BANK1_STROBE : BANK0_STROBE;
          next_addr = req_addr[ROW_LSB +: ROW_W];
          next_ras_cnt = CNT_ONE;
          next_state = ST_ROW;
        end
      end
      ST_ROW: begin
        // Column strobe and address wait one cycle (see [R5])
        if (ras_cnt >= RCD_CYC) begin
          next_addr = open_col;
          next_col_n = STROBE_ALL;
          next_col_cnt = CNT_ONE;
          next_state = ST_COL;
        end
      end
      ST_COL: begin
        // Sample at the latest access path (see [R7] [R8] [R6] [R16])
        if (col_cnt >= colacc_cyc && ras_cnt >= rac_cyc) begin
          next_col_n = STROBE_IDLE;
          next_we_n = 1'b1;
          next_oe = 1'b0;
          next_rvalid = 1'b1;
          if (!cur_write) begin
            next_rdata = data_bus_in;
          end
          next_state = ST_PAGE;
        end
      end
      ST_PAGE: begin
        if (take) begin
          // Row stays open; column precharge spans this cycle and the ST_ROW cycle (see [R13])
          next_state = ST_ROW;
        end else if (close_wanted && ras_cnt >= tras_cyc &&
                     col_cnt >= lead_cyc) begin
          // Row width and column lead met (see [R4] [R10])
          next_row_n = STROBE_IDLE;
          next_pre_cnt = CNT_ONE;
          next_state = ST_PRECH;
        end
      end
      ST_PRECH: begin
        // Precharge and whole cycle time (see [R4])
        if (pre_cnt >= trp_cyc && ras_cnt >= trc_cyc) begin
          next_state = ST_IDLE;
        end
      end
      ST_REF_COL: begin
        next_row_n = STROBE_ALL;
        next_ras_cnt = CNT_ONE;
        next_ref_done = 1'b1;
        next_state = ST_REF_ROW;
      end
      ST_REF_ROW: begin
        if (ras_cnt >= tras_cyc) begin
          next_row_n = STROBE_IDLE;
          next_col_n = STROBE_IDLE;
          next_pre_cnt = CNT_ONE;
          next_state = ST_PRECH;
        end
      end
      default: begin
        next_row_n = STROBE_IDLE;
        next_col_n = STROBE_IDLE;
        next_state = ST_INIT;
      end
    endcase
    // Latch the accepted request; write enable and data lead the
    // column strobe by a cycle, so every write is early (see [R15])
    if (take) begin
      next_bank = req_addr[BANK_BIT];
      next_row = req_addr[ROW_LSB +: ROW_W];
      next_col = req_addr[COL_LSB +: COL_W];
      next_write = req_write;
      next_we_n = !req_write;  // Reads keep it high (see [R11] [R12])
      next_dout = req_wdata;
      next_oe = req_write;
    end
  end

  // State and pin registers
  always_ff @(posedge clk or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      state <= ST_INIT;
      row_strobe_n <= STROBE_IDLE;
      column_strobe_n <= STROBE_IDLE;
      mux_address <= '0;
      write_enable_n <= 1'b1;
      data_bus_out <= '0;
      data_bus_oe <= 1'b0;
      resp_rdata <= '0;
      resp_valid <= 1'b0;
      ref_done <= 1'b0;
      open_bank <= 1'b0;
      open_row <= '0;
      open_col <= '0;
      cur_write <= 1'b0;
      ras_cnt <= '1;
      col_cnt <= '1;
      pre_cnt <= '1;
    end else begin
      state <= next_state;
      row_strobe_n <= next_row_n;
      column_strobe_n <= next_col_n;
      mux_address <= next_addr;
      write_enable_n <= next_we_n;
      data_bus_out <= next_dout;
      data_bus_oe <= next_oe;
      resp_rdata <= next_rdata;
      resp_valid <= next_rvalid;
      ref_done <= next_ref_done;
      open_bank <= next_bank;
      open_row <= next_row;
      open_col <= next_col;
      cur_write <= next_write;
      ras_cnt <= next_ras_cnt;
      col_cnt <= next_col_cnt;
      pre_cnt <= next_pre_cnt;
    end
  end

  // Pin-level width counters for the checks below
  logic row_high, row_high_d, col_high_d;
  logic [CNT_W-1:0] low_len, high_len, fall_gap, col_gap;
  assign row_high = &row_strobe_n;
  always_ff @(posedge clk or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      row_high_d <= 1'b1;
      col_high_d <= 1'b1;
      low_len <= '0;
      high_len <= '1;
      fall_gap <= '1;
      col_gap <= '1;
    end else begin
      row_high_d <= row_high;
      col_high_d <= &column_strobe_n;
      low_len <= row_high ? '0 : sat_inc(low_len);
      high_len <= row_high ? sat_inc(high_len) : '0;
      fall_gap <= (row_high_d && !row_high) ? CNT_ONE : sat_inc(fall_gap);
      col_gap <= (col_high_d && !(&column_strobe_n)) ? CNT_ONE :
        sat_inc(col_gap);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!sys_rst_b);

  AST_ROW_WIDTH: assert property ( // see [R4]
    $rose(row_high) |-> low_len >= tras_cyc && low_len <= RAS_MAX_CYC)
    else $error("row strobe low width out of range");
  AST_ROW_PRECHARGE: assert property ( // see [R4]
    $fell(row_high) |-> high_len >= trp_cyc)
    else $error("row strobe precharge too short");
  AST_ROW_CYCLE: assert property ( // see [R4]
    $fell(row_high) |-> fall_gap >= trc_cyc)
    else $error("random cycle time too short");
  AST_COL_AFTER_ROW: assert property ( // see [R5]
    $fell(&column_strobe_n) && !row_high |-> $past(!row_high))
    else $error("column strobe fell too soon after row strobe");
  AST_COL_HIGH_FIRST: assert property ( // see [R9]
    $fell(row_high) && (&column_strobe_n) |-> $past(&column_strobe_n))
    else $error("column strobe not high before row strobe fell");
  AST_COL_LEAD: assert property ( // see [R10]
    $rose(row_high) && $past(state) == ST_PAGE |->
      $past(col_cnt) >= lead_cyc)
    else $error("column address lead too short");
  AST_READ_WE: assert property ( // see [R11] [R12]
    !(&column_strobe_n) && !row_high && !cur_write |-> write_enable_n)
    else $error("write enable active during a read");
  AST_EARLY_WRITE: assert property ( // see [R15]
    $fell(&column_strobe_n) && !write_enable_n |->
      $past(!write_enable_n) && $past(data_bus_oe) && data_bus_oe)
    else $error("write not set up before column strobe");
  AST_PAGE_GAP: assert property ( // see [R13]
    $fell(&column_strobe_n) |-> col_gap >= HPC_CYC)
    else $error("page access spacing too short");
  AST_HOLD_INIT: assert property ( // see [R18]
    !grade_ready |-> row_high && !req_ready)
    else $error("access before the grade was read");
endmodule
`default_nettype wire

/* verilog/refresh_pacer.sv */
// Refresh interval timer with a sticky pending flag
`timescale 1ns/1ps
`default_nettype none
module refresh_pacer (
  input wire logic clk,
  input wire logic sys_rst_b,
  input wire logic refresh_done,
  output logic refresh_due
);
  import dram_host_pkg::*;

  logic [CNT_W-1:0] timer;      // Cycles since the last interval tick
  logic [CNT_W-1:0] next_timer;
  logic next_due;
  logic tick;
  logic [CNT_W-1:0] since_done; // Assertion helper only

  assign tick = (timer >= REF_SPACING_CYC - CNT_ONE);

  // Interval is shortened by a margin that covers closing an open page
  always_comb begin
    next_timer = tick ? '0 : timer + CNT_ONE;
    next_due = refresh_due;
    if (refresh_done) begin
      next_due = 1'b0;
    end
    // A tick in the clearing cycle wins (see [R3])
    if (tick) begin
      next_due = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      timer <= '0;
      refresh_due <= 1'b0;
      since_done <= '0;
    end else begin
      timer <= next_timer;
      refresh_due <= next_due;
      since_done <= refresh_done ? '0 : since_done + CNT_ONE;
    end
  end

  AST_REFRESH_PACE: assert property ( // see [R3]
    @(posedge clk) disable iff (!sys_rst_b)
    since_done <= REF_DEADLINE_CYC)
    else $error("row refresh spacing exceeded");
endmodule
`default_nettype wire

/* verilog/speed_grade_select.sv */
// Start-up reader of the speed-grade pins and per-grade cycle counts
`timescale 1ns/1ps
`default_nettype none
module speed_grade_select (
  input wire logic clk,
  input wire logic sys_rst_b,
  input wire logic speed_id_pin0,
  input wire logic speed_id_pin1,
  input wire logic speed_id_pin2,
  input wire logic speed_id_pin3,
  output logic grade_ready,
  output logic grade_slow,
  output logic grade_unknown,
  output logic [dram_host_pkg::CNT_W-1:0] tras_cyc,
  output logic [dram_host_pkg::CNT_W-1:0] trp_cyc,
  output logic [dram_host_pkg::CNT_W-1:0] trc_cyc,
  output logic [dram_host_pkg::CNT_W-1:0] rac_cyc,
  output logic [dram_host_pkg::CNT_W-1:0] lead_cyc,
  output logic [dram_host_pkg::CNT_W-1:0] colacc_cyc
);
  import dram_host_pkg::*;

  logic [CNT_W-1:0] settle;   // Cycles since reset release, stops at STRAP_SETTLE_CYC
  logic [CNT_W-1:0] next_settle;
  logic next_ready;
  logic next_slow;
  logic next_unknown;
  logic odd_id;               // Any pin other than the third is grounded

  assign odd_id = !(speed_id_pin0 && speed_id_pin1 && speed_id_pin3);

  // Wait for the pins to settle, then take one sample and hold it
  always_comb begin
    next_settle = settle;
    next_ready = grade_ready;
    next_slow = grade_slow;
    next_unknown = grade_unknown;
    if (!grade_ready) begin
      if (settle >= STRAP_SETTLE_CYC) begin
        next_ready = 1'b1;
        // Grounded third pin marks the slow grade (see [R14])
        // An unknown code falls back to the slow, safe timing
        next_slow = !speed_id_pin2 || odd_id;
        next_unknown = odd_id;
      end else begin
        next_settle = settle + CNT_ONE;
      end
    end
  end

  // Sample registers; counts only change together with the grade
  always_ff @(posedge clk or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      settle <= '0;
      grade_ready <= 1'b0;
      grade_slow <= 1'b1;
      grade_unknown <= 1'b0;
    end else begin
      settle <= next_settle;
      grade_ready <= next_ready;
      grade_slow <= next_slow;
      grade_unknown <= next_unknown;
    end
  end

  // Per-grade counts follow the held grade (see [R18])
  always_comb begin
    tras_cyc = CNT_W'(cyc_up(grade_slow ? T_RAS_S_NS : T_RAS_F_NS));
    trp_cyc = CNT_W'(cyc_up(grade_slow ? T_RP_S_NS : T_RP_F_NS));
    trc_cyc = CNT_W'(cyc_up(grade_slow ? T_RC_S_NS : T_RC_F_NS));
    rac_cyc = CNT_W'(cyc_up(grade_slow ? T_RAC_S_NS : T_RAC_F_NS));
    colacc_cyc = grade_slow ?
      CNT_W'(max3(cyc_up(T_CAC_S_NS), cyc_up(T_AA_S_NS), cyc_up(T_HPC_S_NS))) :
      CNT_W'(max3(cyc_up(T_CAC_F_NS), cyc_up(T_AA_F_NS), cyc_up(T_HPC_F_NS)));
    lead_cyc = grade_slow ?
      CNT_W'(max3(cyc_up(T_LEAD_S_NS), cyc_up(T_CSH_S_NS),
                  cyc_up(T_HPC_S_NS) + cyc_up(T_RHCP_S_NS))) :
      CNT_W'(max3(cyc_up(T_LEAD_F_NS), cyc_up(T_CSH_F_NS),
                  cyc_up(T_HPC_F_NS) + cyc_up(T_RHCP_F_NS)));
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!sys_rst_b);

  AST_GRADE_FROM_PIN: assert property ( // see [R14]
    $rose(grade_ready) |->
      grade_slow == ($past(!speed_id_pin2) || $past(odd_id)))
    else $error("grade does not match the sampled pins");
endmodule
`default_nettype wire
